// ### bench/schp_host_model.sv
module schp_host_model
(
  // Clock
  input wire logic i_clk,
  // Host pins
  output schp_pkg::schp_strobes_s o_strobes,
  output logic [15:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Selects stay negated unless a scenario asks
  initial
  begin
    o_strobes = 5'h1F;
    o_data = 16'h0000;
  end

  // Level held n clocks; n of 4 or more keeps the phase spacing
  task automatic pin(input int idx, input logic lvl, input logic [15:0] d, input int n);
    o_data <= d;
    o_strobes[idx] <= lvl;
    repeat (n) @(posedge i_clk);
  endtask
endmodule // schp_host_model

// ### bench/schp_host_port_assertions.sv
module schp_host_port_chk
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Watched ports
  input wire schp_pkg::schp_strobes_s i_strobes,
  input wire logic i_dma_active,
  input wire logic o_ready_irq_n,
  input wire logic o_is_secondary,
  input wire schp_pkg::schp_mode_e o_mode,
  input wire schp_pkg::schp_select_s o_select,
  input wire logic o_wr_valid,
  input wire logic o_udma_stop,
  input wire logic o_core_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  AST_INIT_BUSY: assert property ($fell(i_sys_rst) |-> (o_core_reset && !o_ready_irq_n) [*8])
    else $error("busy not held after reset");
  AST_INIT_ENDS: assert property ($fell(i_sys_rst) |-> ##[150:260] !o_core_reset)
    else $error("init never ends");
  AST_WR_RISE: assert property (o_wr_valid |-> $past(i_strobes.io_write_strobe_n, 3))
    else $error("write before strobe rise");
  AST_WR_MODE: assert property (o_wr_valid |-> o_mode != schp_pkg::SCHP_MODE_MEM)
    else $error("write taken in memory mode");
  AST_WR_PULSE: assert property (o_wr_valid |=> !o_wr_valid)
    else $error("write pulse too long");
  AST_SEL_IDE: assert property (o_select.task_file_en || o_select.ctrl_block_en |->
    o_mode == schp_pkg::SCHP_MODE_IDE)
    else $error("task file select outside ide");
  AST_DMA_MASK: assert property (o_select.dma_word |-> !o_select.task_file_en && !o_select.ctrl_block_en)
    else $error("select during dma");
  AST_DMA_IGN: assert property (o_select.dma_word |-> $past(i_dma_active) || $past(i_dma_active, 2))
    else $error("dma ack taken while idle");
  AST_STOP: assert property (o_udma_stop |-> o_mode == schp_pkg::SCHP_MODE_IDE && !o_wr_valid)
    else $error("stop outside ide");
  AST_POS: assert property (!o_core_reset && $past(!o_core_reset) |-> $stable(o_is_secondary))
    else $error("drive position moved");

  cover property (o_wr_valid);
  cover property (o_udma_stop);
  cover property (o_select.dma_word);
endmodule // schp_host_port_chk

bind schp_host_port schp_host_port_chk i_chk (
  .i_clk(i_clk),
  .i_sys_rst(i_sys_rst),
  .i_strobes(i_strobes),
  .i_dma_active(i_dma_active),
  .o_ready_irq_n(o_ready_irq_n),
  .o_is_secondary(o_is_secondary),
  .o_mode(o_mode),
  .o_select(o_select),
  .o_wr_valid(o_wr_valid),
  .o_udma_stop(o_udma_stop),
  .o_core_reset(o_core_reset)
);

// ### bench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Position strap grounded while memory and IO modes run
  logic clk = 0, rst = 1, rpin = 1, ide_n = 1, pos_n = 0, attr = 1, iocfg = 0;
  logic lvl = 0, ev = 0, clr = 0, srst = 0, busy = 0, udma = 0, dma = 0;
  logic rdy, sec, wv, stop, crst;
  logic [15:0] wd, hd, nw = 0, ns = 0;
  schp_pkg::schp_mode_e mode;
  schp_pkg::schp_select_s sel;
  schp_pkg::schp_strobes_s stb;
  int fails = 0, n_compared = 0;

  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    nw <= nw + 16'(wv === 1'b1);
    ns <= ns + 16'(stop === 1'b1);
  end

  schp_host_model i_host (.i_clk(clk), .o_strobes(stb), .o_data(hd));
  schp_host_port i_dut (.i_clk(clk), .i_sys_rst(rst), .i_reset_pin(rpin), .i_ide_mode_strap_n(ide_n),
    .i_drive_position_strap_n(pos_n), .i_strobes(stb), .i_data(hd), .i_reg_attr_sel(attr),
    .i_io_configured(iocfg), .i_irq_level_mode(lvl), .i_irq_event(ev), .i_irq_clear(clr),
    .i_soft_reset(srst), .i_core_busy(busy), .i_udma_active(udma), .i_dma_active(dma),
    .o_ready_irq_n(rdy), .o_is_secondary(sec), .o_mode(mode), .o_select(sel), .o_wr_valid(wv),
    .o_wr_data(wd), .o_udma_stop(stop), .o_core_reset(crst));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_init();
    for (int i = 0; i < 300 && crst !== 1'b0; i++)
      cyc(1);
    chk(crst, 0);
    cyc(3);
  endtask

  // No host access until init is over
  task automatic reinit();
    rst <= 1;
    cyc(10);
    rst <= 0;
    cyc(2);
    chk(rdy, 0);
    wait_init();
  endtask

  task automatic wr(input logic [15:0] d);
    i_host.pin(2, 0, d, 4);
    i_host.pin(2, 1, d, 4);
    i_host.pin(2, 1, ~d, 4);
  endtask

  task automatic t_mem();
    chk(mode, schp_pkg::SCHP_MODE_MEM);
    chk(rdy, 1);
    busy <= 1;
    cyc(3);
    chk(rdy, 0);
    busy <= 0;
    wr(16'hA5A5);
    chk(nw, 0);
    i_host.pin(1, 0, 16'h0000, 6);
    chk(sel.mem_read, 1);
    i_host.pin(1, 1, 16'h0000, 6);
    srst <= 1;
    cyc(4);
    chk(crst, 1);
    srst <= 0;
    wait_init();
  endtask

  task automatic t_io();
    iocfg <= 1;
    cyc(3);
    chk(mode, schp_pkg::SCHP_MODE_IO);
    wr(16'h5A3C);
    chk(nw, 1);
    chk(wd, 16'h5A3C);
    i_host.pin(1, 0, 16'h0000, 6);
    chk(sel.mem_read, 0);
    i_host.pin(1, 1, 16'h0000, 4);
    attr <= 0;
    i_host.pin(1, 0, 16'h0000, 6);
    chk(sel.card_info_cfg_read, 1);
    i_host.pin(1, 1, 16'h0000, 4);
    lvl <= 1;
    ev <= 1;
    cyc(1);
    ev <= 0;
    cyc(20);
    chk(rdy, 0);
    clr <= 1;
    cyc(1);
    clr <= 0;
    cyc(3);
    chk(rdy, 1);
    lvl <= 0;
    ev <= 1;
    cyc(1);
    ev <= 0;
    cyc(3);
    chk(rdy, 0);
    cyc(20);
    chk(rdy, 1);
  endtask

  task automatic t_ide();
    ide_n <= 0;
    iocfg <= 0;
    attr <= 1;
    rpin <= 1;
    reinit();
    chk(mode, schp_pkg::SCHP_MODE_IDE);
    chk(sec, 0);
    i_host.pin(4, 0, 16'h0000, 6);
    chk(sel.task_file_en, 1);
    i_host.pin(4, 1, 16'h0000, 6);
    i_host.pin(3, 0, 16'h0000, 6);
    chk({sel.ctrl_block_en, sel.task_file_en}, 2);
    i_host.pin(3, 1, 16'h0000, 6);
    wr(16'hC3F0);
    chk(nw, 2);
    // Strobe already negated here
    udma <= 1;
    wr(16'h1234);
    chk(ns, 1);
    chk(nw, 2);
    udma <= 0;
    dma <= 1;
    i_host.pin(0, 0, 16'h0000, 6);
    chk(sel.dma_word, 1);
    dma <= 0;
    cyc(4);
    chk(sel.dma_word, 0);
    i_host.pin(0, 1, 16'h0000, 4);
    pos_n <= 1;
    reinit();
    chk(sec, 1);
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    // Pin held active from power must not block init
    reinit();
    chk(crst, 0);
    rpin <= 0;
    cyc(4);
    t_mem();
    t_io();
    t_ide();
    stop_test();
  end

  // Run needs about 1000 clocks; generous margin
  initial
  begin
    #100us;
    fails++;
    stop_test();
  end
endmodule // testbench

// ### rtl/schp_host_port.sv
module schp_host_port
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Host pins
  input wire logic i_reset_pin,
  input wire logic i_ide_mode_strap_n,
  input wire logic i_drive_position_strap_n,
  input wire schp_pkg::schp_strobes_s i_strobes,
  input wire logic [15:0] i_data,
  input wire logic i_reg_attr_sel,
  // Core side
  input wire logic i_io_configured,
  input wire logic i_irq_level_mode,
  input wire logic i_irq_event,
  input wire logic i_irq_clear,
  input wire logic i_soft_reset,
  input wire logic i_core_busy,
  input wire logic i_udma_active,
  input wire logic i_dma_active,
  // Outputs
  output logic o_ready_irq_n,
  output logic o_is_secondary,
  output schp_pkg::schp_mode_e o_mode,
  output schp_pkg::schp_select_s o_select,
  output logic o_wr_valid,
  output logic [15:0] o_wr_data,
  output logic o_udma_stop,
  output logic o_core_reset
);

  // Three stage synchronisers; stage 1 read only by stage 2
  localparam int NS = 8;
  logic [NS-1:0] raw;
  logic [NS-1:0] s1_r, s2_r, s3_r, st_r;
  assign raw = {i_strobes, i_reset_pin, i_ide_mode_strap_n, i_drive_position_strap_n};

  genvar g;
  generate
    for (g = 0; g < NS; g++)
    begin : g_sync
      always_ff @(posedge i_clk)
      begin
        if (i_sys_rst)
        begin
          s1_r[g] <= 1'b1;
          s2_r[g] <= 1'b1;
          s3_r[g] <= 1'b1;
          st_r[g] <= 1'b1;
        end
        else
        begin
          s1_r[g] <= raw[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g])
            st_r[g] <= s2_r[g]; // [RQ20]
        end
      end
    end
  endgenerate

  schp_pkg::schp_strobes_s stb, stb_prev_r;
  logic reset_pin, ide_strap_n, pos_strap_n;
  assign stb = st_r[7:3];
  assign reset_pin = st_r[2];
  assign ide_strap_n = st_r[1];
  assign pos_strap_n = st_r[0];

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      stb_prev_r <= '1;
    else
      stb_prev_r <= stb;
  end

  // Data sampled two clocks after strobe rising edge; host holds it that long past the edge
  logic [15:0] d1_r, d2_r;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      d1_r <= 16'h0000;
      d2_r <= 16'h0000;
    end
    else
    begin
      d1_r <= i_data;
      d2_r <= d1_r;
    end
  end

  // Drive position and IDE strap caught once after reset settles; memory/IO mode then follows i_io_configured
  localparam int CNT_W_L = schp_pkg::CNT_W;
  localparam logic [CNT_W_L-1:0] INIT_MAX = CNT_W_L'(schp_pkg::INIT_CYCLES);
  // Straps read only once the synchronisers have settled
  localparam logic [CNT_W_L-1:0] STRAP_AT = CNT_W_L'(schp_pkg::STRAP_CYCLE);
  logic strap_done_r;
  logic [CNT_W_L-1:0] init_cnt_r;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_mode <= schp_pkg::SCHP_MODE_MEM;
      o_is_secondary <= 1'b1;
      strap_done_r <= 1'b0;
    end
    else if (!strap_done_r && init_cnt_r == STRAP_AT)
    begin
      strap_done_r <= 1'b1;
      o_is_secondary <= pos_strap_n; // [RQ4]
      if (!ide_strap_n)
        o_mode <= schp_pkg::SCHP_MODE_IDE; // [RQ13]
      else if (i_io_configured)
        o_mode <= schp_pkg::SCHP_MODE_IO;
    end
    else if (strap_done_r && o_mode != schp_pkg::SCHP_MODE_IDE)
      o_mode <= i_io_configured ? schp_pkg::SCHP_MODE_IO : schp_pkg::SCHP_MODE_MEM;
  end

  // Pin reset: level depends on mode; disabled if asserted since power-up
  logic pin_rst_act, pin_seen_idle_r;
  assign pin_rst_act = (o_mode == schp_pkg::SCHP_MODE_IDE) ? !reset_pin : reset_pin; // [RQ18]
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      pin_seen_idle_r <= 1'b0;
    else if (strap_done_r && !pin_rst_act)
      pin_seen_idle_r <= 1'b1; // [RQ16]
  end

  logic do_reset;
  assign do_reset = (pin_seen_idle_r && pin_rst_act) || i_soft_reset; // [RQ18]

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || do_reset)
      init_cnt_r <= '0; // [RQ15]
    else if (init_cnt_r != INIT_MAX)
      init_cnt_r <= init_cnt_r + CNT_W_L'(1);
  end

  logic init_done;
  assign init_done = init_cnt_r == INIT_MAX;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_core_reset <= 1'b1;
    else
      o_core_reset <= !init_done;
  end

  // Address decode
  logic dma_ack;
  assign dma_ack = i_dma_active && !stb.dma_ack_n; // [RQ19]
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_select <= '0;
    else
    begin
      o_select.task_file_en <= (o_mode == schp_pkg::SCHP_MODE_IDE) && !dma_ack
        && !stb.primary_chip_select_n; // [RQ1] [RQ3]
      o_select.ctrl_block_en <= (o_mode == schp_pkg::SCHP_MODE_IDE) && !dma_ack
        && !stb.secondary_chip_select_n; // [RQ2] [RQ3]
      o_select.dma_word <= dma_ack; // [RQ3]
      o_select.mem_read <= (o_mode == schp_pkg::SCHP_MODE_MEM) && !stb.output_enable_n; // [RQ11]
      o_select.card_info_cfg_read <= (o_mode != schp_pkg::SCHP_MODE_IDE) && !stb.output_enable_n
        && !i_reg_attr_sel; // [RQ11] [RQ12]
    end
  end

  // Write strobe or Ultra DMA stop
  logic wr_rise, wr_fall, wr_path;
  assign wr_rise = stb.io_write_strobe_n && !stb_prev_r.io_write_strobe_n;
  assign wr_fall = !stb.io_write_strobe_n && stb_prev_r.io_write_strobe_n;
  assign wr_path = (o_mode == schp_pkg::SCHP_MODE_IO)
    || (o_mode == schp_pkg::SCHP_MODE_IDE && !i_udma_active); // [RQ8]
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_wr_valid <= 1'b0;
      o_wr_data <= 16'h0000;
      o_udma_stop <= 1'b0;
    end
    else
    begin
      o_wr_valid <= wr_path && wr_rise && init_done; // [RQ6] [RQ7]
      if (wr_path && wr_rise)
        o_wr_data <= d2_r; // [RQ7]
      o_udma_stop <= (o_mode == schp_pkg::SCHP_MODE_IDE) && i_udma_active && wr_fall; // [RQ10]
    end
  end

  // Ready/busy or interrupt request
  localparam logic [7:0] PULSE_MAX = 8'(schp_pkg::IRQ_PULSE_CYCLES);
  logic [7:0] pulse_cnt_r;
  logic irq_level_r;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || do_reset)
    begin
      irq_level_r <= 1'b0;
      pulse_cnt_r <= 8'h00;
    end
    else
    begin
      if (i_irq_event && i_irq_level_mode)
        irq_level_r <= 1'b1;
      else if (i_irq_clear || !i_irq_level_mode)
        irq_level_r <= 1'b0;
      if (i_irq_event && !i_irq_level_mode)
        pulse_cnt_r <= PULSE_MAX;
      else if (pulse_cnt_r != 8'h00)
        pulse_cnt_r <= pulse_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !init_done)
      o_ready_irq_n <= 1'b0; // [RQ15]
    else if (o_mode == schp_pkg::SCHP_MODE_IO)
      o_ready_irq_n <= !(irq_level_r || pulse_cnt_r != 8'h00); // [RQ17]
    else
      o_ready_irq_n <= !i_core_busy; // [RQ14]
  end

endmodule // schp_host_port

// ### rtl/schp_pkg.sv
// What this block and its host do
// [RQ1] IDE mode: primary select enables task-file registers
// [RQ2] IDE mode: secondary select reaches alt-status, control
// [RQ3] DMA ack: selects negated, transfers sixteen bits
// [RQ4] Position strap pulled up: ground primary, open secondary
// [RQ5] Memory/IO modes: host ties strap to A25/ground
// [RQ6] IO mode: write strobe captures bus data
// [RQ7] Write data latched on strobe rising edge
// [RQ8] IDE without Ultra DMA: pin is write strobe
// [RQ9] Host negates strobe before entering Ultra DMA
// [RQ10] Ultra DMA: strobe assertion stops current burst
// [RQ11] Memory mode: output enable drives read data
// [RQ12] IO mode: output enable reads card info only
// [RQ13] Grounded mode strap selects IDE operation
// [RQ14] Memory mode: ready high, busy low
// [RQ15] Busy after power-up/reset until init completes
// [RQ16] Reset held from power-up: pin reset disabled
// [RQ17] IO mode: ready pin becomes active-low interrupt
// [RQ18] Memory/IO reset on high pin or soft-reset
// [RQ19] DMA ack ignored while no DMA active
// [RQ20] Host strobes synchronised before edge detection
package schp_pkg;
  localparam int CLK_MHZ = 200;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYCLES = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int IRQ_PULSE_NS = 50;
  localparam int IRQ_PULSE_CYCLES = (IRQ_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 16;
  localparam int STRAP_CYCLE = 4;
  localparam logic [2:0] SYNC_RESET = 3'h7;

  typedef enum logic [2:0]
  {
    SCHP_MODE_MEM = 3'h1,
    SCHP_MODE_IO = 3'h2,
    SCHP_MODE_IDE = 3'h4
  } schp_mode_e;

  typedef struct packed
  {
    logic primary_chip_select_n;
    logic secondary_chip_select_n;
    logic io_write_strobe_n;
    logic output_enable_n;
    logic dma_ack_n;
  } schp_strobes_s;

  typedef struct packed
  {
    logic task_file_en;
    logic ctrl_block_en;
    logic card_info_cfg_read;
    logic mem_read;
    logic dma_word;
  } schp_select_s;
endpackage
